// [design/bnmp_host.sv]
// Host controller driving a byte-wide nonvolatile memory through its pins
`timescale 1ns/1ps
module bnmp_host
	import bnmp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [BNMP_AW-1:0] req_addr,
	input wire logic [BNMP_DW-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [BNMP_DW-1:0] rsp_rdata,
	output logic ce_n,
	output logic we_n,
	output logic oe_n,
	output logic [BNMP_AW-1:0] addr_in,
	input wire logic [BNMP_DW-1:0] data_io_in,
	output logic [BNMP_DW-1:0] data_io_out,
	output logic data_io_oe
);
	bnmp_state_t state;
	bnmp_state_t next_state;
	logic [BNMP_CW-1:0] cnt;
	logic [BNMP_CW-1:0] next_cnt;
	logic wr;
	logic next_wr;
	logic next_req_ready;
	logic next_rsp_valid;
	logic [BNMP_DW-1:0] next_rsp_rdata;
	logic next_ce_n;
	logic next_we_n;
	logic next_oe_n;
	logic [BNMP_AW-1:0] next_addr_in;
	logic [BNMP_DW-1:0] next_data_io_out;
	logic next_data_io_oe;
	logic pwr_good;
	logic [BNMP_DW-1:0] rd_sync;
	// Supply-good pin synchronised before use
	bnmp_sync u_pwr (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.rst_val(1'b0),
		.pin(supply_ok),
		.level(pwr_good)
	);
	// Read data lines come from off chip
	genvar gi;
	generate
		for (gi = 0; gi < BNMP_DW; gi++) begin : g_rd
			bnmp_sync u_rd (
				.ref_clk(ref_clk),
				.rst_b(rst_b),
				.rst_val(1'b0),
				.pin(data_io_in[gi]),
				.level(rd_sync[gi])
			);
		end
	endgenerate
	// Sequencer: one select strobe per access, then precharge
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_wr = wr;
		next_req_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		next_ce_n = ce_n;
		next_we_n = we_n;
		next_oe_n = oe_n;
		next_addr_in = addr_in;
		next_data_io_out = data_io_out;
		next_data_io_oe = data_io_oe;
		unique case (state)
			BNMP_LOCK: begin
				// [R18] Select held high
				next_ce_n = 1'b1;
				// [R19] Strobe high too
				next_we_n = 1'b1;
				next_oe_n = 1'b1;
				next_data_io_oe = 1'b0;
				if (pwr_good) begin
					next_state = BNMP_IDLE;
					next_req_ready = 1'b1;
				end
			end
			BNMP_IDLE: begin
				next_req_ready = pwr_good;
				if (!pwr_good) begin
					next_state = BNMP_LOCK;
				end else if (req_valid && req_ready) begin
					// Address and strobe set before select falls
					next_addr_in = req_addr;
					next_wr = req_write;
					// [R09] Select-controlled write
					next_we_n = !req_write;
					next_oe_n = req_write;
					next_data_io_out = req_wdata;
					next_data_io_oe = req_write;
					next_req_ready = 1'b0;
					next_state = BNMP_SETUP;
				end
			end
			BNMP_SETUP: begin
				// [R04] Fresh falling edge
				// [R16] One per access
				next_ce_n = 1'b0;
				// Select stays low past access time until read data clears the synchroniser
				next_cnt = BNMP_CW'(BNMP_ACCESS_CYC + BNMP_SYNC_CYC);
				next_state = BNMP_ACCESS;
			end
			BNMP_ACCESS: begin
				// [R12] Hold access time
				// [R15] Low time bounded
				if (cnt > BNMP_CNT_ONE) begin
					next_cnt = cnt - BNMP_CNT_ONE;
				end else begin
					// [R11] Select rise ends write
					// [R14] Precharge begins
					next_ce_n = 1'b1;
					next_we_n = 1'b1;
					next_oe_n = 1'b1;
					next_data_io_oe = 1'b0;
					if (!wr) begin
						// [R07] Data valid after access
						next_rsp_rdata = rd_sync;
					end
					// [R13] No polling needed
					next_rsp_valid = 1'b1;
					next_cnt = BNMP_CW'(BNMP_PRECHARGE_CYC);
					next_state = BNMP_PRECHG;
				end
			end
			BNMP_PRECHG: begin
				// [R14] Minimum high time
				if (cnt > BNMP_CNT_ONE) begin
					next_cnt = cnt - BNMP_CNT_ONE;
				end else begin
					next_cnt = BNMP_CNT_ZERO;
					next_state = pwr_good ? BNMP_IDLE : BNMP_LOCK;
					next_req_ready = pwr_good;
				end
			end
			default: begin
				next_state = BNMP_LOCK;
			end
		endcase
	end
	// State registers; pins idle deselected
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= BNMP_LOCK;
			cnt <= BNMP_CNT_ZERO;
			wr <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			addr_in <= 15'h0000;
			data_io_out <= 8'h00;
			data_io_oe <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			wr <= next_wr;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_rdata <= next_rsp_rdata;
			ce_n <= next_ce_n;
			we_n <= next_we_n;
			oe_n <= next_oe_n;
			addr_in <= next_addr_in;
			data_io_out <= next_data_io_out;
			data_io_oe <= next_data_io_oe;
		end
	end
endmodule : bnmp_host

// [design/bnmp_pkg.sv]
// Constants and types for the byte-wide nonvolatile memory host controller
// What the document requires
// [R01] Memory has 32768 bytes, 15-bit address, 8 data bits each.
// [R02] Rows are 64 bits; every 8-byte boundary starts a new row.
// [R03] Read and write share one cycle time and one access time.
// [R04] Each cycle starts on chip-select falling edge, which captures address.
// [R05] Internal cycle completes even if chip select rises early.
// [R06] Address changes after capture are ignored until next falling edge.
// [R07] Device drives data only with output drive low and access time met.
// [R08] Output drive control high keeps device data lines high impedance.
// [R09] Write strobe low at chip-select fall makes a write; device never drives.
// [R10] Write strobe falling later starts as read until the strobe falls.
// [R11] Array write ends on first rising edge of strobe or chip select.
// [R12] Host holds strobe and select low for access time, data set up.
// [R13] Writes finish in the bus cycle; no ready, no polling needed.
// [R14] Precharge starts when select rises; host holds it high minimum time.
// [R15] Host never holds chip select low beyond the maximum low time.
// [R16] Host starts every access with a fresh select falling edge.
// [R17] Device never blocks accesses within its operating supply range.
// [R18] Host keeps chip select high while supply is below minimum; an access already under way still runs to its end.
// [R19] With select tied low, host keeps write strobe high at power cycles.
// [R20] With select high, device ignores inputs and leaves data undriven.
package bnmp_pkg;
	localparam int BNMP_AW = 15;
	localparam int BNMP_DW = 8;
	localparam int BNMP_CLK_PS = 4000;
	// Device timing in picoseconds
	localparam int BNMP_ACCESS_PS = 70000;
	localparam int BNMP_PRECHARGE_PS = 60000;
	localparam int BNMP_SETUP_PS = 30000;
	localparam int BNMP_CE_LOW_MAX_PS = 10000000;
	// Least times round up, longest time rounds down
	localparam int BNMP_ACCESS_CYC = (BNMP_ACCESS_PS + BNMP_CLK_PS - 1) / BNMP_CLK_PS;
	localparam int BNMP_PRECHARGE_CYC = (BNMP_PRECHARGE_PS + BNMP_CLK_PS - 1) / BNMP_CLK_PS;
	localparam int BNMP_SETUP_CYC = (BNMP_SETUP_PS + BNMP_CLK_PS - 1) / BNMP_CLK_PS;
	localparam int BNMP_CE_LOW_MAX_CYC = BNMP_CE_LOW_MAX_PS / BNMP_CLK_PS;
	// Read-back path latency: three flops, agreement stage, one spare cycle
	localparam int BNMP_SYNC_CYC = 5;
	localparam int BNMP_CW = 8;
	localparam logic [BNMP_CW-1:0] BNMP_CNT_ZERO = 8'h00;
	localparam logic [BNMP_CW-1:0] BNMP_CNT_ONE = 8'h01;
	typedef enum logic [2:0] {
		BNMP_IDLE = 3'b000,
		BNMP_SETUP = 3'b001,
		BNMP_ACCESS = 3'b010,
		BNMP_PRECHG = 3'b011,
		BNMP_LOCK = 3'b100
	} bnmp_state_t;
endpackage : bnmp_pkg

// [design/bnmp_sync.sv]
// Three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module bnmp_sync (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic rst_val,
	input wire logic pin,
	output logic level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;
	// Accept a change once second and third stages agree
	always_comb begin
		next_level = level;
		if (s2 == s3) begin
			next_level = s3;
		end
	end
	// Register chain; every stage resets to zero, rst_val is not used
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
			level <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			level <= next_level;
		end
	end
endmodule : bnmp_sync

// [test/bnmp_mem.sv]
// Behavioural byte-wide memory on the host pins
`timescale 1ns/1ps
module bnmp_mem
	import bnmp_pkg::*;
#(
	parameter int HOLD_NS = 20
)
(
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [BNMP_AW-1:0] addr_in,
	input wire logic [BNMP_DW-1:0] wdata,
	output logic [BNMP_DW-1:0] rdata
);
	logic [BNMP_DW-1:0] mem [0:32767];
	logic [BNMP_AW-1:0] lat = 15'h0000;
	logic wr = 1'b0;
	logic ok = 1'b0;
	wire en;
	wire [BNMP_DW-1:0] wd;
	assign #1 wd = wdata;
	always @(negedge ce_n) begin
		lat = addr_in;
		wr = !we_n;
		ok = 1'b0;
		ok <= #(BNMP_ACCESS_PS / 1000) 1'b1;
	end
	// late strobe turns read into write
	always @(negedge we_n) if (!ce_n) wr = 1'b1;
	always @(posedge we_n or posedge ce_n) begin
		if (wr) mem[lat] = wd;
		wr = 1'b0;
	end
	assign #(0, HOLD_NS) en = !ce_n && !oe_n && !wr && ok;
	assign rdata = en ? mem[lat] : ~mem[lat];
endmodule : bnmp_mem

// [test/bnmp_host_properties.sv]
// Pin checks for the memory host
`timescale 1ns/1ps
module bnmp_host_properties
	import bnmp_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic supply_ok,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic ce_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [BNMP_AW-1:0] addr_in,
	input wire logic [BNMP_DW-1:0] data_io_out,
	input wire logic data_io_oe
);
	logic [11:0] lo;
	logic [11:0] hi;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Select low and high run lengths
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lo <= 12'h000;
			hi <= 12'hfff;
		end else begin
			lo <= ce_n ? 12'h000 : lo + 12'h001;
			hi <= !ce_n ? 12'h000 : (hi == 12'hfff ? hi : hi + 12'h001);
		end
	end
	AST_LOW_MIN: assert property ($rose(ce_n) |-> lo >= BNMP_ACCESS_CYC) else $error("select low too short");
	AST_PRECHARGE: assert property ($fell(ce_n) |-> hi >= BNMP_PRECHARGE_CYC) else $error("precharge short");
	AST_LOW_MAX: assert property (!ce_n |-> lo < BNMP_CE_LOW_MAX_CYC) else $error("select low too long");
	// Supply pin passes the synchroniser, so an access may start up to six cycles late
	AST_SUPPLY: assert property (!supply_ok [*7] |-> !$fell(ce_n)) else $error("access at low supply");
	AST_WE_HIGH: assert property (ce_n && !we_n |=> !ce_n) else $error("strobe low unselected");
	AST_WDATA: assert property (!ce_n && !we_n |-> data_io_oe && $stable(data_io_out)) else $error("write data moved");
	AST_NO_CLASH: assert property (!oe_n |-> !data_io_oe && we_n) else $error("bus clash");
	AST_ADDR: assert property (!ce_n |-> $stable(addr_in)) else $error("address moved");
	AST_ANSWER: assert property (req_valid && req_ready |=> !req_ready ##24 rsp_valid) else $error("late answer");
endmodule : bnmp_host_properties
bind bnmp_host bnmp_host_properties u_bnmp_host_properties (.*);

// [test/bnmp_host_bench.sv]
// Self-checking bench for the memory host
`timescale 1ns/1ps
module bnmp_host_bench;
	import bnmp_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic supply_ok = 1'b1;
	logic req_valid = 1'b0;
	logic req_write = 1'b0;
	logic [BNMP_AW-1:0] req_addr = 15'h0000;
	logic [BNMP_DW-1:0] req_wdata = 8'h00;
	logic req_ready, rsp_valid, ce_n, we_n, oe_n, data_io_oe;
	logic [BNMP_DW-1:0] rsp_rdata, data_io_out, mem_q;
	logic [BNMP_AW-1:0] addr_in;
	wire [BNMP_DW-1:0] data_io = data_io_oe ? data_io_out : mem_q;
	int error_cnt = 0;
	int checked = 0;
	int falls = 0;
	logic [BNMP_AW-1:0] tab [4] = '{15'h0000, 15'h0007, 15'h0008, 15'h7fff};
	always #2 ref_clk = ~ref_clk;
	always @(negedge ce_n) falls++;
	bnmp_host u_bnmp_host (.ref_clk(ref_clk), .rst_b(rst_b), .supply_ok(supply_ok), .req_valid(req_valid),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
		.addr_in(addr_in), .data_io_in(data_io), .data_io_out(data_io_out), .data_io_oe(data_io_oe));
	bnmp_mem u_bnmp_mem (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr_in(addr_in), .wdata(data_io), .rdata(mem_q));
	task results;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : results
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, s);
			error_cnt++;
		end
	endtask : chk
	// One request, waits for acceptance and answer
	task op(input logic w, input logic [BNMP_AW-1:0] a, input logic [BNMP_DW-1:0] d);
		int n;
		n = 0;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		@(negedge ref_clk);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		chk("wait", n < 300, 1);
		if (n >= 300) results();
	endtask : op
	// Row edges and last byte, reads straight after writes
	task sc_data;
		for (int i = 0; i < 4; i++) op(1'b1, tab[i], 8'h11 * (i + 1));
		for (int i = 0; i < 4; i++) begin
			op(1'b0, tab[i], 8'h00);
			chk("rdata", rsp_rdata, 8'h11 * (i + 1));
		end
	endtask : sc_data
	// Low supply holds off a pending request
	task sc_supply;
		int f0;
		supply_ok = 1'b0;
		repeat (10) @(negedge ref_clk);
		f0 = falls;
		req_valid = 1'b1;
		repeat (40) @(negedge ref_clk);
		chk("falls", falls, f0);
		chk("ce_n", ce_n, 1);
		supply_ok = 1'b1;
		op(1'b0, tab[3], 8'h00);
		chk("rdata", rsp_rdata, 8'h44);
	endtask : sc_supply
	initial begin
		repeat (6) @(negedge ref_clk);
		rst_b = 1'b1;
		sc_data();
		sc_supply();
		results();
	end
endmodule : bnmp_host_bench
